// ---- rtl/pph_port.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - forward bytes go out on the eight data lines.
// - busy high means not ready; no new byte starts until it falls.
// - select high is shown as on-line status.
// - a low pulse on ack marks the byte as done.
// - fault low is reported as a peripheral error.
// - a low pulse on init resets the link to idle.
// - strobe low latches the byte; data stays stable meanwhile.
// - select-in low selects the peripheral, high deselects it.
// - auto-feed level is settable by the system.
// - a direction output steers data pins and external buffer.
// - interrupt requests fire on handshake and fault events.
// - forward data goes through a two-word buffer; reverse data is sampled into a register.
module pph_port
    import pph_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    input wire logic rx_sample,
    input wire logic dir_reverse,
    input wire logic select_cfg,
    input wire logic autofd_cfg,
    input wire logic init_req,
    output logic online,
    output logic error,
    output logic paper_err,
    output logic busy_stat,
    output logic irq_ack,
    output logic irq_fault,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic pd_oe_n,
    output logic buf_dir,
    input wire logic busy_pin,
    input wire logic select_pin,
    input wire logic ack_n_pin,
    input wire logic fault_n_pin,
    input wire logic perror_pin,
    output logic strobe_n,
    output logic init_n,
    output logic select_in_n,
    output logic autofd_n
);
    // 3-stage synchronisers; stage 2 and 3 agreement accepts a change
    logic [4:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    logic [7:0] d1_q, d2_q, d3_q, rx_q, rx_d;
    logic [7:0] pdo_q, pdo_d;
    logic busy_s, sel_s, ackn_s, fltn_s, perr_s, ackn_prev_q;
    logic ack_fall;
    logic ack_seen_q, ack_seen_d, ack_done;
    logic [7:0] bdata;
    logic bvalid, bready;
    pph_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic stb_q, stb_d, ini_q, ini_d, oen_q, oen_d, dir_q, dir_d;
    logic sel_q, afd_q, onl_q, err_q, per_q, bsy_q, ia_q, ia_d, if_q, if_d, fltn_prev_q;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n - 1);
    endfunction

    always_comb begin
        flt_d = flt_q;
        for (int i = 0; i < 5; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                flt_d[i] = s3_q[i];
            end
        end
    end
    assign busy_s = flt_q[0];
    assign sel_s = flt_q[1];
    assign ackn_s = flt_q[2];
    assign fltn_s = flt_q[3];
    assign perr_s = flt_q[4];
    assign ack_fall = ackn_prev_q && !ackn_s;
    // an ack that lands during strobe or hold counts once the hold is over
    assign ack_done = ack_fall || ack_seen_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            flt_q <= PIN_RST;
            ackn_prev_q <= 1'b1;
            fltn_prev_q <= 1'b1;
            d1_q <= DATA_RST;
            d2_q <= DATA_RST;
            d3_q <= DATA_RST;
        end else begin
            s1_q <= {perror_pin, fault_n_pin, ack_n_pin, select_pin, busy_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= flt_d;
            ackn_prev_q <= ackn_s;
            fltn_prev_q <= fltn_s;
            d1_q <= pd_in;
            d2_q <= d1_q;
            d3_q <= d2_q;
        end
    end

    // buffer keeps a word when the port is stalled on busy or ack
    pph_buf2 u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(bdata),
        .out_valid(bvalid),
        .out_ready(bready)
    );

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        stb_d = 1'b1;
        ini_d = 1'b1;
        pdo_d = pdo_q;
        bready = 1'b0;
        ia_d = 1'b0;
        ack_seen_d = ack_seen_q;
        if_d = !fltn_s && fltn_prev_q;
        dir_d = dir_reverse;
        oen_d = dir_reverse;
        rx_d = rx_q;
        if (rx_sample && dir_q) begin
            rx_d = (d2_q == d3_q) ? d3_q : rx_q;
        end
        unique case (st_q)
            PPH_IDLE: begin
                if (init_req) begin
                    st_d = PPH_INIT;
                    cnt_d = cyc(INIT_CYC);
                end else if (bvalid && !dir_reverse && !dir_q) begin
                    bready = 1'b1;
                    pdo_d = bdata;
                    st_d = PPH_BUSYWAIT;
                end
            end
            PPH_BUSYWAIT: begin
                if (!busy_s) begin
                    st_d = PPH_SETUP;
                    cnt_d = cyc(SETUP_CYC);
                end
            end
            PPH_SETUP: begin
                if (cnt_q == '0) begin
                    st_d = PPH_STROBE;
                    cnt_d = cyc(STROBE_CYC);
                    stb_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            PPH_STROBE: begin
                if (ack_fall) begin
                    ack_seen_d = 1'b1;
                end
                if (cnt_q == '0) begin
                    st_d = PPH_HOLD;
                    cnt_d = cyc(HOLD_CYC);
                end else begin
                    stb_d = 1'b0;
                    cnt_d = cnt_q - 1'b1;
                end
            end
            PPH_HOLD: begin
                if (ack_fall) begin
                    ack_seen_d = 1'b1;
                end
                if (cnt_q == '0) begin
                    st_d = PPH_ACKWAIT;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            PPH_ACKWAIT: begin
                if (ack_done) begin
                    ia_d = 1'b1;
                    ack_seen_d = 1'b0;
                    st_d = PPH_IDLE;
                end else if (init_req) begin
                    st_d = PPH_INIT;
                    cnt_d = cyc(INIT_CYC);
                end
            end
            PPH_INIT: begin
                if (cnt_q == '0) begin
                    st_d = PPH_IDLE;
                end else begin
                    ini_d = 1'b0;
                    cnt_d = cnt_q - 1'b1;
                end
            end
        endcase
        if (st_q == PPH_IDLE && init_req) begin
            ini_d = 1'b0;
        end
        if (st_q == PPH_ACKWAIT && !ack_done && init_req) begin
            ini_d = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= PPH_IDLE;
            cnt_q <= '0;
            stb_q <= 1'b1;
            ini_q <= 1'b1;
            pdo_q <= DATA_RST;
            oen_q <= 1'b1;
            dir_q <= 1'b1;
            rx_q <= DATA_RST;
            ia_q <= 1'b0;
            if_q <= 1'b0;
            ack_seen_q <= 1'b0;
            sel_q <= 1'b1;
            afd_q <= 1'b1;
            onl_q <= 1'b0;
            err_q <= 1'b0;
            per_q <= 1'b0;
            bsy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            stb_q <= stb_d;
            ini_q <= ini_d;
            pdo_q <= pdo_d;
            oen_q <= oen_d;
            dir_q <= dir_d;
            rx_q <= rx_d;
            ia_q <= ia_d;
            if_q <= if_d;
            ack_seen_q <= ack_seen_d;
            sel_q <= !select_cfg;
            afd_q <= !autofd_cfg;
            onl_q <= sel_s;
            err_q <= !fltn_s;
            per_q <= perr_s;
            bsy_q <= busy_s;
        end
    end

    assign rx_data = rx_q;
    assign pd_out = pdo_q;
    assign pd_oe_n = oen_q;
    assign buf_dir = dir_q;
    assign strobe_n = stb_q;
    assign init_n = ini_q;
    assign select_in_n = sel_q;
    assign autofd_n = afd_q;
    assign online = onl_q;
    assign error = err_q;
    assign paper_err = per_q;
    assign busy_stat = bsy_q;
    assign irq_ack = ia_q;
    assign irq_fault = if_q;
endmodule // pph_port
`default_nettype wire

// ---- rtl/pph_pkg.sv ----
package pph_pkg;
    // strobe setup, width and hold around the low pulse, in ns
    localparam int SETUP_NS = 500;
    localparam int STROBE_NS = 500;
    localparam int HOLD_NS = 500;
    localparam int INIT_NS = 2000;
    localparam int CLK_MHZ = 50;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;
    // filtered pins after reset: {perror, fault_n, ack_n, select, busy}
    localparam logic [4:0] PIN_RST = 5'h0C;
    typedef enum logic [2:0] {
        PPH_IDLE, PPH_BUSYWAIT, PPH_SETUP, PPH_STROBE, PPH_HOLD, PPH_ACKWAIT, PPH_INIT
    } pph_state_t;
endpackage

// ---- rtl/pph_buf2.sv ----
`timescale 1ns/1ns
`default_nettype none
module pph_buf2 (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    logic [7:0] m0_q, m0_d, m1_q, m1_d;
    logic [1:0] cnt_q, cnt_d;
    logic wr, rd;
    logic rdy_q, rdy_d;
    // ready comes from a flop so the port output is registered
    assign in_ready = rdy_q;
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = m0_q;
    always_comb begin
        wr = in_valid && in_ready;
        rd = out_valid && out_ready;
        m0_d = m0_q;
        m1_d = m1_q;
        cnt_d = cnt_q;
        if (rd) begin
            m0_d = m1_q;
        end
        if (wr) begin
            if (cnt_q == 2'h0 || (cnt_q == 2'h1 && rd)) begin
                m0_d = in_data;
            end else begin
                m1_d = in_data;
            end
        end
        if (wr && !rd) begin
            cnt_d = cnt_q + 2'h1;
        end else if (rd && !wr) begin
            cnt_d = cnt_q - 2'h1;
        end
        rdy_d = (cnt_d != 2'h2);
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m0_q <= 8'h00;
            m1_q <= 8'h00;
            cnt_q <= 2'h0;
            rdy_q <= 1'b1;
        end else begin
            m0_q <= m0_d;
            m1_q <= m1_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end
endmodule // pph_buf2
`default_nettype wire

// ---- testbench/pph_port_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module pph_port_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dir_reverse,
    input wire logic select_cfg,
    input wire logic autofd_cfg,
    input wire logic [7:0] pd_out,
    input wire logic pd_oe_n,
    input wire logic buf_dir,
    input wire logic busy_pin,
    input wire logic select_pin,
    input wire logic fault_n_pin,
    input wire logic busy_stat,
    input wire logic online,
    input wire logic error,
    input wire logic irq_ack,
    input wire logic strobe_n,
    input wire logic init_n,
    input wire logic select_in_n,
    input wire logic autofd_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    hold_data_a: assert property (!strobe_n && !$past(strobe_n) |->
        $stable(pd_out) && !pd_oe_n) else $error("data moved while strobe low");
    rev_release_a: assert property (buf_dir |-> pd_oe_n)
        else $error("data driven in reverse");
    dir_follow_a: assert property ($rose(dir_reverse) |-> ##[1:2] buf_dir)
        else $error("direction did not follow");
    ctl_level_a: assert property (rst_n ##1 1 |-> select_in_n == !$past(select_cfg)
        && autofd_n == !$past(autofd_cfg)) else $error("control level wrong");
    busy_block_a: assert property ($fell(strobe_n) |->
        !busy_stat && !$past(busy_pin, 8)) else $error("strobe while busy");
    strobe_width_a: assert property ($fell(strobe_n) |->
        (!strobe_n throughout ##24 1) ##1 strobe_n) else $error("strobe width wrong");
    online_lvl_a: assert property (select_pin [*6] |-> online)
        else $error("online not shown");
    fault_lvl_a: assert property (!fault_n_pin [*6] |-> error)
        else $error("fault not shown");
    ack_pulse_a: assert property (irq_ack |-> strobe_n ##1 !irq_ack)
        else $error("ack interrupt malformed");
    init_pulse_a: assert property ($fell(init_n) |-> !init_n [*8])
        else $error("init pulse too short");
endmodule // pph_port_chk
bind pph_port pph_port_chk u_chk (.mclk, .rst_n, .dir_reverse, .select_cfg, .autofd_cfg,
    .pd_out, .pd_oe_n, .buf_dir, .busy_pin, .select_pin, .fault_n_pin, .busy_stat, .online,
    .error, .irq_ack, .strobe_n, .init_n, .select_in_n, .autofd_n);
`default_nettype wire

// ---- testbench/pph_periph.sv ----
`timescale 1ns/1ns
`default_nettype none
module pph_periph (
    input wire logic mclk,
    input wire logic strobe_n,
    input wire logic [7:0] pd,
    input wire logic stall,
    output logic busy,
    output logic ack_n,
    output logic [7:0] got,
    output logic got_stb
);
    logic busy_q = 1'b0;
    assign busy = busy_q | stall;
    initial begin
        ack_n = 1'b1;
        got = 8'h00;
        got_stb = 1'b0;
        forever begin
            @(negedge strobe_n);
            got = pd;
            busy_q = 1'b1;
            @(posedge strobe_n);
            @(posedge mclk);
            got_stb <= 1'b1;
            @(posedge mclk);
            got_stb <= 1'b0;
            repeat (3) @(posedge mclk);
            ack_n <= 1'b0;
            repeat (5) @(posedge mclk);
            ack_n <= 1'b1;
            busy_q <= 1'b0;
        end
    end
endmodule // pph_periph
`default_nettype wire

// ---- testbench/ieee1284_compat_host_port_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module ieee1284_compat_host_port_test;
    logic mclk = 0, rst_n = 0, tx_valid = 0, rx_sample = 0, dir_reverse = 0, select_cfg = 0;
    logic autofd_cfg = 0, init_req = 0, select_pin = 0, fault_pin = 0, perror_pin = 0, stall = 0;
    logic [7:0] tx_data = 8'h00, rev = 8'h00, rx_data, pd_out, pd_in, got;
    logic tx_ready, online, error, paper_err, busy_stat, irq_ack, irq_fault, pd_oe_n, buf_dir;
    logic busy_pin, ack_n_pin, fault_n_pin, strobe_n, init_n, select_in_n, autofd_n, got_stb;
    logic [7:0] expq[$];
    logic [31:0] seed = 32'hA804;
    int err_count = 0, num_checks = 0, n_ack = 0, n_flt = 0, i;
    always #10 mclk = ~mclk;
    assign pd_in = pd_oe_n ? rev : pd_out;
    assign fault_n_pin = !(fault_pin | perror_pin);
    pph_port uut (.mclk, .rst_n, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_sample,
        .dir_reverse, .select_cfg, .autofd_cfg, .init_req, .online, .error, .paper_err,
        .busy_stat, .irq_ack, .irq_fault, .pd_in, .pd_out, .pd_oe_n, .buf_dir, .busy_pin,
        .select_pin, .ack_n_pin, .fault_n_pin, .perror_pin, .strobe_n, .init_n,
        .select_in_n, .autofd_n);
    pph_periph peer (.mclk, .strobe_n, .pd(pd_in), .stall, .busy(busy_pin),
        .ack_n(ack_n_pin), .got, .got_stb);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic send();
        seed = xs(seed);
        tx_data = seed[7:0];
        tx_valid = 1;
        for (i = 0; i < 3000 && tx_ready !== 1'b1; i++) tick(1);
        if (i == 3000) begin
            err_count++;
            summarize();
        end
        expq.push_back(tx_data);
        tick(1);
        tx_valid = 0;
        // let an edge pass so a following call never re-raises valid in this step
        tick(1);
    endtask
    task automatic drain();
        for (i = 0; i < 20000 && expq.size() != 0; i++) tick(1);
        // a hang here means the port stopped; report straight away
        if (i == 20000) begin
            err_count++;
            summarize();
        end
    endtask
    // the monitor owns the queue head, so ordering is checked against push order
    always @(posedge mclk) begin
        if (irq_ack === 1'b1) n_ack++;
        if (irq_fault === 1'b1) n_flt++;
        if (got_stb === 1'b1) chk(got, expq.size() ? expq.pop_front() : ~got);
    end
    initial begin
        #1500000;
        err_count++;
        summarize();
    end
    initial begin
        tick(8);
        rst_n = 1;
        select_cfg = 1;
        autofd_cfg = 1;
        select_pin = 1;
        tick(8);
        chk({3'h0, select_in_n, autofd_n, online, pd_oe_n, buf_dir}, 8'h04);
        stall = 1;
        // busy must be through the pin filter before a byte is offered
        tick(6);
        repeat (3) send();
        tick(60);
        chk({5'h0, tx_ready, strobe_n, busy_stat}, 8'h03);
        stall = 0;
        repeat (5) send();
        drain();
        // last ack interrupt follows the strobe hold time
        tick(40);
        chk(8'(n_ack), 8'h08);
        select_cfg = 0;
        autofd_cfg = 0;
        tick(3);
        chk({6'h0, select_in_n, autofd_n}, 8'h03);
        dir_reverse = 1;
        seed = xs(seed);
        rev = seed[7:0];
        tick(6);
        chk({6'h0, pd_oe_n, buf_dir}, 8'h03);
        rx_sample = 1;
        tick(1);
        rx_sample = 0;
        tick(4);
        chk(rx_data, rev);
        dir_reverse = 0;
        perror_pin = 1;
        tick(8);
        chk({6'h0, error, paper_err}, 8'h03);
        chk(8'(n_flt), 8'h01);
        perror_pin = 0;
        init_req = 1;
        tick(1);
        init_req = 0;
        tick(3);
        chk({7'h0, init_n}, 8'h00);
        for (i = 0; i < 300 && init_n !== 1'b1; i++) tick(1);
        chk({7'h0, init_n}, 8'h01);
        if (i == 300) summarize();
        send();
        drain();
        summarize();
    end
endmodule // ieee1284_compat_host_port_test
`default_nettype wire
